// file: verilog/rdm_pkg.sv
package rdm_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] RDM_OFF_LEVEL = 8'h00;
  localparam logic [7:0] RDM_OFF_STATUS = 8'h04;
  localparam logic [7:0] RDM_OFF_MASK = 8'h08;
  localparam logic [7:0] RDM_OFF_CTRL = 8'h0c;
  localparam logic [7:0] RDM_OFF_SUMMARY = 8'h10;

  // ==========================================================
  // Defect vector bit positions
  // ==========================================================
  localparam int RDM_NDEF = 11;
  localparam int RDM_B_MOD_IN_LOSS = 0;
  localparam int RDM_B_MOD_FAIL = 1;
  localparam int RDM_B_TX_FAIL = 2;
  localparam int RDM_B_TX_IN_LOSS = 3;
  localparam int RDM_B_RX_SIG_LOSS = 4;
  localparam int RDM_B_RX_FAIL = 5;
  localparam int RDM_B_DEM_IN_LOSS = 6;
  localparam int RDM_B_ERR_RATE = 7;
  localparam int RDM_B_HOP_MISMATCH = 8;
  localparam int RDM_B_DEM_FAIL = 9;
  localparam int RDM_B_PROT_FAIL = 10;

  // Defects that force all-ones onto the receive traffic.
  localparam logic [10:0] RDM_AIS_SET = 11'h370;

  // ==========================================================
  // Control register fields and reset values
  // ==========================================================
  localparam int RDM_C_AIS_EN = 0;
  localparam int RDM_C_TRANSMITTER_INPUT_LOSS_OK = 1;
  localparam int RDM_C_RXLOS_OK = 2;
  localparam int RDM_C_DEM_OK = 3;
  localparam logic [3:0] RDM_CTRL_RST = 4'h1;
  localparam logic [10:0] RDM_MASK_RST = 11'h000;

  // ==========================================================
  // Summary state encoding
  // ==========================================================
  typedef enum logic [1:0] {
    RDM_SUM_OK = 2'b00,
    RDM_SUM_TXSIDE = 2'b01,
    RDM_SUM_RXSIDE = 2'b10,
    RDM_SUM_BOTH = 2'b11
  } rdm_sum_t;

endpackage

// file: verilog/rdm_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for a bundle of asynchronous level inputs.
module rdm_sync #(
  parameter int W = 11
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule

`default_nettype wire

// file: verilog/rdm_monitor.sv
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Receive defects force all-ones onto baseband output
// - Error-rate flag alarms only with RDM_C_DEM_OK set; else it folds into demodulator failure and all-ones
// - Hop identity mismatch flag from demodulated data
// - Modulator failure covers faults and input loss
// - Modulator input loss flag, alarm only
// - Transmitter failure flag, alarm only
// - Unsure transmitter input loss reports transmitter failure
// - Unsure receive signal loss reports receiver failure
// - Receiver failure flag from receiver faults
// - Unsure demodulator defects report demodulator failure
// - Demodulator failure flag from demodulator faults
// - Extra primitives exposed on reporting point
// - Protection failure when channels go unprotected
// - Protection failure reported both directions, alarm only
// - Management sees aggregated summary, not raw events
module rdm_monitor #(
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Raw defect conditions from the radio functions (asynchronous)
  input wire logic modInputLossIn,
  input wire logic modFaultIn,
  input wire logic txFaultIn,
  input wire logic txInputLossIn,
  input wire logic rxSignalLossIn,
  input wire logic rxFaultIn,
  input wire logic demodInputLossIn,
  input wire logic errorRateIn,
  input wire logic hopMismatchIn,
  input wire logic demodFaultIn,
  input wire logic protFaultIn,
  // Receive traffic, same clock
  input wire logic [DW-1:0] rxData,
  input wire logic rxValid,
  output logic [DW-1:0] bbData,
  output logic bbValid,
  // Management reporting points
  output logic [10:0] phyMgmtReportPoint,
  output logic switchMgmtReportPointTx,
  output logic switchMgmtReportPointRx,
  output logic aisActive,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq
);
  import rdm_pkg::*;

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  logic [RDM_NDEF-1:0] rawAsync;
  logic [RDM_NDEF-1:0] raw;
  logic [RDM_NDEF-1:0] defect_r;
  logic [RDM_NDEF-1:0] defect_nxt;
  logic [RDM_NDEF-1:0] status_r;
  logic [RDM_NDEF-1:0] mask_r;
  logic [3:0] ctrl_r;
  rdm_sum_t summary_r;
  rdm_sum_t summary_nxt;
  logic ais;
  logic wrEn;
  logic rdEn;
  logic [RDM_NDEF-1:0] clrBits;

  // Gather the raw conditions into one vector.
  assign rawAsync = {protFaultIn, demodFaultIn, hopMismatchIn, errorRateIn,
                     demodInputLossIn, rxFaultIn, rxSignalLossIn, txInputLossIn,
                     txFaultIn, modFaultIn, modInputLossIn};

  rdm_sync #(
    .W(RDM_NDEF)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(rawAsync),
    .dout(raw)
  );

  // ==========================================================
  // Defect flag derivation
  // ==========================================================
  // Flags are levels that follow their conditions each cycle. When a
  // distinction is not trusted, the optional flag folds into the failure.
  always_comb begin
    defect_nxt = '0;
    defect_nxt[RDM_B_MOD_IN_LOSS] = raw[RDM_B_MOD_IN_LOSS];
    defect_nxt[RDM_B_MOD_FAIL] = raw[RDM_B_MOD_FAIL] | raw[RDM_B_MOD_IN_LOSS];
    if (ctrl_r[RDM_C_TRANSMITTER_INPUT_LOSS_OK]) begin
      defect_nxt[RDM_B_TX_FAIL] = raw[RDM_B_TX_FAIL];
      defect_nxt[RDM_B_TX_IN_LOSS] = raw[RDM_B_TX_IN_LOSS];
    end else begin
      defect_nxt[RDM_B_TX_FAIL] = raw[RDM_B_TX_FAIL] | raw[RDM_B_TX_IN_LOSS];
    end
    if (ctrl_r[RDM_C_RXLOS_OK]) begin
      defect_nxt[RDM_B_RX_FAIL] = raw[RDM_B_RX_FAIL];
      defect_nxt[RDM_B_RX_SIG_LOSS] = raw[RDM_B_RX_SIG_LOSS];
    end else begin
      defect_nxt[RDM_B_RX_FAIL] = raw[RDM_B_RX_FAIL] | raw[RDM_B_RX_SIG_LOSS];
    end
    if (ctrl_r[RDM_C_DEM_OK]) begin
      defect_nxt[RDM_B_DEM_FAIL] = raw[RDM_B_DEM_FAIL];
      defect_nxt[RDM_B_DEM_IN_LOSS] = raw[RDM_B_DEM_IN_LOSS];
      defect_nxt[RDM_B_ERR_RATE] = raw[RDM_B_ERR_RATE];
      defect_nxt[RDM_B_HOP_MISMATCH] = raw[RDM_B_HOP_MISMATCH];
    end else begin
      defect_nxt[RDM_B_DEM_FAIL] = raw[RDM_B_DEM_FAIL] | raw[RDM_B_DEM_IN_LOSS] |
                                   raw[RDM_B_ERR_RATE] | raw[RDM_B_HOP_MISMATCH];
    end
    defect_nxt[RDM_B_PROT_FAIL] = raw[RDM_B_PROT_FAIL];
  end

  // Registered defect levels.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      defect_r <= '0;
    end else begin
      defect_r <= defect_nxt;
    end
  end

  // ==========================================================
  // Receive traffic with all-ones insertion
  // ==========================================================
  // Only the receive-path failures in the set replace traffic; the
  // error-rate flag is excluded from it.
  assign ais = ctrl_r[RDM_C_AIS_EN] & (|(defect_r & RDM_AIS_SET));

  // Output traffic register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bbData <= '0;
      bbValid <= 1'b0;
      aisActive <= 1'b0;
    end else begin
      bbValid <= rxValid;
      aisActive <= ais;
      bbData <= ais ? {DW{1'b1}} : rxData;
    end
  end

  // ==========================================================
  // Management reporting
  // ==========================================================
  // Full defect set on the physical-interface point, including the
  // optional primitives; the switch failure goes to both directions.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phyMgmtReportPoint <= '0;
      switchMgmtReportPointTx <= 1'b0;
      switchMgmtReportPointRx <= 1'b0;
    end else begin
      phyMgmtReportPoint <= defect_r;
      switchMgmtReportPointTx <= defect_r[RDM_B_PROT_FAIL];
      switchMgmtReportPointRx <= defect_r[RDM_B_PROT_FAIL];
    end
  end

  // Aggregated summary state for management.
  always_comb begin
    summary_nxt = RDM_SUM_OK;
    case ({|defect_r[RDM_B_DEM_FAIL:RDM_B_RX_SIG_LOSS],
           |defect_r[RDM_B_TX_IN_LOSS:RDM_B_MOD_IN_LOSS]})
      2'b00: summary_nxt = RDM_SUM_OK;
      2'b01: summary_nxt = RDM_SUM_TXSIDE;
      2'b10: summary_nxt = RDM_SUM_RXSIDE;
      2'b11: summary_nxt = RDM_SUM_BOTH;
      default: summary_nxt = RDM_SUM_OK;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      summary_r <= RDM_SUM_OK;
    end else begin
      summary_r <= summary_nxt;
    end
  end

  // ==========================================================
  // APB slave
  // ==========================================================
  // Zero-wait-state slave; writes land at the access cycle.
  assign pready = 1'b1;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == RDM_OFF_LEVEL) || (a == RDM_OFF_STATUS) ||
               (a == RDM_OFF_MASK) || (a == RDM_OFF_CTRL) || (a == RDM_OFF_SUMMARY);
  endfunction

  assign pslverr = psel & penable & ~isMapped(paddr);
  assign clrBits = (wrEn && paddr == RDM_OFF_STATUS) ? pwdata[RDM_NDEF-1:0] : '0;

  // Control and mask registers.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r <= RDM_CTRL_RST;
      mask_r <= RDM_MASK_RST;
    end else if (wrEn) begin
      if (paddr == RDM_OFF_CTRL) begin
        ctrl_r <= pwdata[3:0];
      end
      if (paddr == RDM_OFF_MASK) begin
        mask_r <= pwdata[RDM_NDEF-1:0];
      end
    end
  end

  // Sticky status: a new defect wins over a write-one clear.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~clrBits) | defect_r;
    end
  end

  // Read data register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        RDM_OFF_LEVEL: prdata <= {21'h0, defect_r};
        RDM_OFF_STATUS: prdata <= {21'h0, status_r};
        RDM_OFF_MASK: prdata <= {21'h0, mask_r};
        RDM_OFF_CTRL: prdata <= {28'h0, ctrl_r};
        RDM_OFF_SUMMARY: prdata <= {29'h0, ais, summary_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  assign irq = |(status_r & mask_r);

  // ==========================================================
  // Assertions
  // ==========================================================
  a_ais_forces_ones: assert property (@(posedge mclk) disable iff (!rst_n)
    (ais && rxValid) |=> (bbData == {DW{1'b1}}))
    else $error("all-ones not inserted during receive defect");

  a_errrate_no_ais: assert property (@(posedge mclk) disable iff (!rst_n)
    (defect_r[RDM_B_ERR_RATE] && ((defect_r & RDM_AIS_SET) == '0)) |-> !ais)
    else $error("error-rate flag alone caused all-ones");

  a_mod_fail_covers: assert property (@(posedge mclk) disable iff (!rst_n)
    raw[RDM_B_MOD_IN_LOSS] |=> defect_r[RDM_B_MOD_FAIL])
    else $error("modulator failure missed input loss");

  a_tx_fold: assert property (@(posedge mclk) disable iff (!rst_n)
    (raw[RDM_B_TX_IN_LOSS] && !ctrl_r[RDM_C_TRANSMITTER_INPUT_LOSS_OK]) |=>
    (defect_r[RDM_B_TX_FAIL] && !defect_r[RDM_B_TX_IN_LOSS]))
    else $error("transmitter input loss not folded");

  a_rx_fold: assert property (@(posedge mclk) disable iff (!rst_n)
    (raw[RDM_B_RX_SIG_LOSS] && !ctrl_r[RDM_C_RXLOS_OK]) |=> defect_r[RDM_B_RX_FAIL])
    else $error("receive signal loss not folded");

  a_dem_fold: assert property (@(posedge mclk) disable iff (!rst_n)
    (raw[RDM_B_HOP_MISMATCH] && !ctrl_r[RDM_C_DEM_OK]) |=> defect_r[RDM_B_DEM_FAIL])
    else $error("demodulator defect not folded");

  a_prot_both: assert property (@(posedge mclk) disable iff (!rst_n)
    defect_r[RDM_B_PROT_FAIL] |=> (switchMgmtReportPointTx && switchMgmtReportPointRx))
    else $error("protection failure not reported both ways");

  a_ais_release: assert property (@(posedge mclk) disable iff (!rst_n)
    ((defect_r & RDM_AIS_SET) == '0) |=> !aisActive)
    else $error("all-ones held after defects cleared");

  // Each trusted flag follows its synchronised condition one edge later.
  a_mod_in_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    raw[RDM_B_MOD_IN_LOSS] |=> defect_r[RDM_B_MOD_IN_LOSS])
    else $error("modulator input loss flag missing");

  a_tx_fail_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    raw[RDM_B_TX_FAIL] |=> defect_r[RDM_B_TX_FAIL])
    else $error("transmitter failure flag missing");

  a_rx_fail_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    raw[RDM_B_RX_FAIL] |=> defect_r[RDM_B_RX_FAIL])
    else $error("receiver failure flag missing");

  a_dem_fail_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    raw[RDM_B_DEM_FAIL] |=> defect_r[RDM_B_DEM_FAIL])
    else $error("demodulator failure flag missing");

  a_hop_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (raw[RDM_B_HOP_MISMATCH] && ctrl_r[RDM_C_DEM_OK]) |=> defect_r[RDM_B_HOP_MISMATCH])
    else $error("hop identity mismatch flag missing");

  a_errrate_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (raw[RDM_B_ERR_RATE] && ctrl_r[RDM_C_DEM_OK]) |=> defect_r[RDM_B_ERR_RATE])
    else $error("error-rate flag missing");

  a_prot_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    raw[RDM_B_PROT_FAIL] |=> defect_r[RDM_B_PROT_FAIL])
    else $error("protection failure flag missing");

  a_rx_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (!raw[RDM_B_RX_FAIL] && !raw[RDM_B_RX_SIG_LOSS]) |=> !defect_r[RDM_B_RX_FAIL])
    else $error("receiver failure flag held without condition");

  // Reporting carries alarms only and never touches the traffic.
  a_prot_no_ais: assert property (@(posedge mclk) disable iff (!rst_n)
    (defect_r == (11'h001 << RDM_B_PROT_FAIL)) |-> !ais)
    else $error("protection failure caused all-ones");

  a_report_level: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> (phyMgmtReportPoint == $past(defect_r)))
    else $error("reporting point does not follow defect flags");

  a_summary_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    (defect_r == '0) |=> (summary_r == RDM_SUM_OK))
    else $error("summary not idle without defects");

  // Register side: sticky bits catch every flag, read data stands after access.
  a_status_sets: assert property (@(posedge mclk) disable iff (!rst_n)
    (|defect_r) |=> ((status_r & $past(defect_r)) == $past(defect_r)))
    else $error("sticky status missed an active flag");

  a_read_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    rdEn |=> $stable(prdata))
    else $error("read data changed right after access");

endmodule

`default_nettype wire

// file: testbench/rdm_mgmt_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Management side of the defect reports
// ==========================================================
// Keeps a log of every alarm seen and notes a split protection report.
module rdm_mgmt_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Reporting points
  input wire logic [10:0] phyMgmtReportPoint,
  input wire logic switchMgmtReportPointTx,
  input wire logic switchMgmtReportPointRx,
  // Log
  output logic [10:0] alarmLog,
  output logic dirSplit
);
  import rdm_pkg::*;
  // Accumulates alarms; both directions must always agree.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alarmLog <= 11'h000;
      dirSplit <= 1'h0;
    end else begin
      alarmLog <= alarmLog | phyMgmtReportPoint;
      dirSplit <= dirSplit | (switchMgmtReportPointTx ^ switchMgmtReportPointRx);
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_radio_defect_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module tb_radio_defect_monitor;
  import rdm_pkg::*;
  typedef struct {logic [3:0] ctrl; int idx; logic [10:0] lvl; logic ais;} rdm_case_t;
  logic mclk, rst_n, psel, penable, pwrite, rxValid, bbValid, pready, pslverr, irq;
  logic aisActive, swTx, swRx, errSeen, dirSplit;
  logic [7:0] paddr, rxData, bbData;
  logic [10:0] rawDef, report, alarmLog;
  logic [31:0] pwdata, prdata, rdVal;
  int num_errors = 0;
  int n_compared = 0;
  rdm_case_t tbl[17];

  rdm_monitor rdm_monitor_inst (.mclk(mclk), .rst_n(rst_n),
    .modInputLossIn(rawDef[0]), .modFaultIn(rawDef[1]), .txFaultIn(rawDef[2]),
    .txInputLossIn(rawDef[3]), .rxSignalLossIn(rawDef[4]), .rxFaultIn(rawDef[5]),
    .demodInputLossIn(rawDef[6]), .errorRateIn(rawDef[7]), .hopMismatchIn(rawDef[8]),
    .demodFaultIn(rawDef[9]), .protFaultIn(rawDef[10]), .rxData(rxData), .rxValid(rxValid),
    .bbData(bbData), .bbValid(bbValid), .phyMgmtReportPoint(report),
    .switchMgmtReportPointTx(swTx), .switchMgmtReportPointRx(swRx), .aisActive(aisActive),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  rdm_mgmt_model rdm_mgmt_model_inst (.mclk(mclk), .rst_n(rst_n),
    .phyMgmtReportPoint(report), .switchMgmtReportPointTx(swTx),
    .switchMgmtReportPointRx(swRx), .alarmLog(alarmLog), .dirSplit(dirSplit));

  // Clock generation.
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // Ends the run with the verdict.
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compares one value with its expectation.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen at an edge.
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) begin
      @(posedge mclk);
    end
    rdVal = prdata;
    errSeen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  // Reads a register and checks data and error response.
  task automatic regRd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    apbXfer(1'h0, a, 32'h0);
    chk(rdVal, exp);
    chk(32'(errSeen), 32'(expErr));
  endtask

  // Applies one defect under a control setting, then removes it.
  task automatic defCase(input rdm_case_t c);
    apbXfer(1'h1, RDM_OFF_CTRL, 32'(c.ctrl));
    rxData <= 8'h30 + 8'(c.idx);
    rawDef <= 11'h001 << c.idx;
    repeat (5) @(posedge mclk);
    chk(32'(report), 32'(c.lvl));
    chk(32'(aisActive), 32'(c.ais));
    chk(32'(bbData), c.ais ? 32'hff : 32'h30 + c.idx);
    chk(32'({swTx, swRx}), {30'h0, {2{c.lvl[10]}}});
    regRd(RDM_OFF_LEVEL, 32'(c.lvl), 1'h0);
    rawDef <= 11'h000;
    repeat (5) @(posedge mclk);
    chk(32'(report), 32'h0);
    chk(32'({aisActive, bbData}), 32'h30 + c.idx);
  endtask

  // Watchdog against a hang.
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    test_done();
  end

  // Main test sequence.
  initial begin
    tbl = '{'{4'h1, 0, 11'h003, 1'h0}, '{4'h1, 1, 11'h002, 1'h0}, '{4'h1, 2, 11'h004, 1'h0},
      '{4'h1, 3, 11'h004, 1'h0}, '{4'h1, 4, 11'h020, 1'h1}, '{4'h1, 5, 11'h020, 1'h1},
      '{4'h1, 6, 11'h200, 1'h1}, '{4'h1, 7, 11'h200, 1'h1}, '{4'h1, 8, 11'h200, 1'h1},
      '{4'h1, 9, 11'h200, 1'h1}, '{4'h1, 10, 11'h400, 1'h0}, '{4'hf, 3, 11'h008, 1'h0},
      '{4'hf, 4, 11'h010, 1'h1}, '{4'hf, 6, 11'h040, 1'h1}, '{4'hf, 7, 11'h080, 1'h0},
      '{4'hf, 8, 11'h100, 1'h1}, '{4'h0, 5, 11'h020, 1'h0}};
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rawDef = 11'h000;
    rxData = 8'h00;
    rxValid = 1'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    rxValid <= 1'h1;
    @(posedge mclk);
    regRd(RDM_OFF_CTRL, 32'h1, 1'h0);
    regRd(RDM_OFF_MASK, 32'h0, 1'h0);
    regRd(RDM_OFF_STATUS, 32'h0, 1'h0);
    regRd(8'h14, 32'h0, 1'h1);
    $display("test registers done");
    foreach (tbl[i]) defCase(tbl[i]);
    chk(32'(bbValid), 32'h1);
    $display("test defects done");
    apbXfer(1'h1, RDM_OFF_CTRL, 32'h1);
    rawDef <= 11'h024;
    repeat (5) @(posedge mclk);
    regRd(RDM_OFF_SUMMARY, 32'h7, 1'h0);
    rawDef <= 11'h000;
    repeat (5) @(posedge mclk);
    regRd(RDM_OFF_SUMMARY, 32'h0, 1'h0);
    $display("test summary done");
    apbXfer(1'h1, RDM_OFF_STATUS, 32'h7ff);
    regRd(RDM_OFF_STATUS, 32'h0, 1'h0);
    rawDef <= 11'h400;
    repeat (5) @(posedge mclk);
    chk(32'(irq), 32'h0);
    regRd(RDM_OFF_STATUS, 32'h400, 1'h0);
    apbXfer(1'h1, RDM_OFF_MASK, 32'h400);
    chk(32'(irq), 32'h1);
    rawDef <= 11'h000;
    repeat (5) @(posedge mclk);
    chk(32'(irq), 32'h1);
    apbXfer(1'h1, RDM_OFF_STATUS, 32'h400);
    chk(32'(irq), 32'h0);
    $display("test interrupt done");
    chk(32'({dirSplit, alarmLog}), 32'h7ff);
    test_done();
  end
endmodule
`default_nettype wire
